/* File: logic/vss_core.sv */
// slew rate, feedback scale and lower output limit command logic
`timescale 1ns/1ps
//
// What this block does
// - the programmed slew shapes target changes in conversion, not turn-on or turn-off.
// - the slew word is linear: signed 5-bit exponent 15:11, mantissa 10:0, in mV/us.
// - the slew exponent resets to minus four, one sixteenth mV/us per mantissa step.
// - valid slew words read back unchanged while the nearest supported rate is applied.
// - slew values from 0.067 to 15.933 mV/us are valid.
// - an out-of-range write to any of the three commands flags invalid data and alerts.
// - the decoded scale picks divider 0.125, 0.25, 0.5 or 1.0 by threshold.
// - scale writes apply at once when idle, else wait for a restore or supply cycle.
// - reference scaling uses the exact programmed scale value.
// - the lower limit is an unsigned 16-bit voltage and the reference goal never goes below it.
// - in conversion a target under the lower limit warns and moves to the limit at slew rate.
// - that warning sets the catch-all, output-voltage and min/max bits and alerts.
// - the lower limit accepts the same range as the upper limit.
// - all three commands are word writes and word reads, answered in kind.
// - in conversion a target over the upper limit clamps to it and warns the same way.
module vss_core
  import vss_pkg::*;
#(
  parameter int          LSB_SHIFT = 5,
  parameter logic [15:0] LIM_MIN   = 16'h0000,
  parameter logic [15:0] LIM_MAX   = 16'hFFFF
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // host word access
  input  wire logic [7:0]  cmd_code,
  input  wire logic        wr_word,
  input  wire logic        rd_word,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] rd_data,
  output logic             rd_valid,
  // power-up and conversion state
  input  wire logic        init_load,
  input  wire vss_init_t   init_val,
  input  wire logic        conv_en,
  input  wire logic        nvm_restore,
  input  wire logic        analog_supply_input_uvlo,
  // target sources
  input  wire logic [15:0] nominal,
  input  wire logic [15:0] trim,
  input  wire logic [15:0] upper_limit,
  input  wire logic        target_upd,
  // reference and loop settings
  output logic      [15:0] ref_target,
  output logic      [15:0] ref_goal,
  output logic      [7:0]  slew_code,
  output logic      [1:0]  divider_sel,
  output logic      [31:0] scale_exact,
  // status
  input  wire logic        clear_faults,
  output vss_status_t      status,
  output logic             alert_n
);

  if (LSB_SHIFT < 0 || LSB_SHIFT > 8) $error("LSB_SHIFT out of range");
  if (LIM_MIN > LIM_MAX) $error("limit range reversed");

  function automatic logic [31:0] lin_to_q(input logic [15:0] w,
                                           input int frac);
    int          sh;
    logic [31:0] m;
    sh = int'($signed(w[EXP_MSB:EXP_LSB])) + frac;
    m  = {21'h0, w[MAN_MSB:0]};
    if (w[MAN_MSB]) lin_to_q = 32'h0000_0000;
    else if (sh > 20) lin_to_q = 32'hFFFF_FFFF;
    else if (sh >= 0) lin_to_q = m << sh;
    else lin_to_q = m >> (-sh);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decode of the host access
  logic [15:0] slew_word_r, scale_word_r, lower_r, scale_hw_r;
  logic [31:0] wr_q8, wr_q16;
  logic        hit_slew, hit_scale, hit_lower, wr_ok, wr_bad;
  logic        lower_wr;

  assign wr_q8     = lin_to_q(wr_data, SLEW_FRAC);
  assign wr_q16    = lin_to_q(wr_data, SCALE_FRAC);
  assign hit_slew  = wr_word && cmd_code == CMD_SLEW;
  assign hit_scale = wr_word && cmd_code == CMD_SCALE;
  assign hit_lower = wr_word && cmd_code == CMD_LOWER;
  assign wr_ok     = hit_slew
                       ? (wr_q8 >= SLEW_MIN_Q8 && wr_q8 <= SLEW_MAX_Q8)
                   : hit_scale
                       ? (wr_q16 != 32'h0000_0000 && wr_q16 <= SCALE_Q_MAX)
                   : (wr_data >= LIM_MIN && wr_data <= LIM_MAX);
  assign wr_bad    = (hit_slew || hit_scale || hit_lower) && !wr_ok;
  assign lower_wr  = hit_lower && wr_ok;

  // analog supply lockout crosses in from a pin
  logic uvlo_s1_r, uvlo_s2_r, uvlo_d_r, supply_back;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      uvlo_s1_r <= 1'b1;
      uvlo_s2_r <= 1'b1;
      uvlo_d_r  <= 1'b1;
    end else begin
      uvlo_s1_r <= analog_supply_input_uvlo;
      uvlo_s2_r <= uvlo_s1_r;
      uvlo_d_r  <= uvlo_s2_r;
    end
  end
  assign supply_back = uvlo_d_r && !uvlo_s2_r;

  ////////////////////////////////////////////////////////////////////////
  // command registers; invalid data is refused and leaves them untouched
  logic scale_apply;
  // a running converter keeps its divider until restore or supply cycle
  assign scale_apply = nvm_restore || supply_back;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slew_word_r  <= {SLEW_EXP_RST, MAN_RST};
      scale_word_r <= {SCALE_EXP_RST, MAN_RST};
      scale_hw_r   <= {SCALE_EXP_RST, MAN_RST};
      lower_r      <= LOWER_RST;
    end else if (init_load) begin
      slew_word_r  <= {slew_word_r[EXP_MSB:EXP_LSB], init_val.slew_mantissa};
      scale_word_r <= {scale_word_r[EXP_MSB:EXP_LSB],
                       init_val.scale_mantissa};
      scale_hw_r   <= {scale_word_r[EXP_MSB:EXP_LSB],
                       init_val.scale_mantissa};
      lower_r      <= init_val.lower;
    end else begin
      if (hit_slew && wr_ok) slew_word_r <= wr_data;
      if (hit_scale && wr_ok) scale_word_r <= wr_data;
      if (lower_wr) lower_r <= wr_data;
      if (hit_scale && wr_ok && !conv_en) scale_hw_r <= wr_data;
      else if (scale_apply) scale_hw_r <= scale_word_r;
    end
  end

  // readback answers each word read one cycle later
  logic [15:0] rd_mux;
  assign rd_mux = cmd_code == CMD_SLEW  ? slew_word_r  :
                  cmd_code == CMD_SCALE ? scale_word_r :
                  cmd_code == CMD_LOWER ? lower_r      : 16'h0000;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_word;
      if (rd_word) rd_data <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // applied slew and divider settings
  logic [31:0] slew_q8, scale_q16, slew_rnd;
  logic [7:0]  code_nxt;
  logic [1:0]  div_nxt;
  assign slew_q8   = lin_to_q(slew_word_r, SLEW_FRAC);
  assign scale_q16 = lin_to_q(scale_hw_r, SCALE_FRAC);
  assign slew_rnd  = (slew_q8 + 32'h0000_0008) >> 4;
  assign code_nxt  = slew_rnd < 32'(SLEW_CODE_MIN) ? SLEW_CODE_MIN :
                     slew_rnd > 32'(SLEW_CODE_MAX) ? SLEW_CODE_MAX :
                     slew_rnd[7:0];
  assign div_nxt   = scale_q16 <= SCALE_Q_125 ? DIV_125 :
                     scale_q16 <= SCALE_Q_250 ? DIV_250 :
                     scale_q16 <= SCALE_Q_500 ? DIV_500 : DIV_1000;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slew_code   <= SLEW_CODE_MIN;
      divider_sel <= DIV_125;
      scale_exact <= 32'h0000_0000;
    end else begin
      slew_code   <= code_nxt;
      divider_sel <= div_nxt;
      scale_exact <= scale_q16;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // target clamp; the lower limit wins if the limits cross
  logic signed [17:0] tsum;
  logic               below, above;
  logic [15:0]        goal_nxt;
  logic               chk_r;
  assign tsum     = $signed({2'b00, nominal}) +
                    $signed({{2{trim[15]}}, trim});
  assign below    = tsum < $signed({2'b00, lower_r});
  assign above    = tsum > $signed({2'b00, upper_limit});
  assign goal_nxt = below || (above && upper_limit < lower_r)
                      ? lower_r
                      : above ? upper_limit : tsum[15:0];

  ////////////////////////////////////////////////////////////////////////
  // reference stepping on a microsecond tick
  logic [7:0]  tick_cnt_r;
  logic        tick;
  logic [15:0] acc_r, acc_sum, step, diff;
  logic [15:0] ref_nxt, acc_nxt;
  logic        reach;

  assign tick    = tick_cnt_r == 8'(TICK_CYC - 1);
  assign acc_sum = acc_r + {8'h00, slew_code};
  assign step    = acc_sum >> LSB_SHIFT;
  assign diff    = ref_goal > ref_target ? ref_goal - ref_target
                                         : ref_target - ref_goal;
  assign reach   = diff <= step;
  always_comb begin
    ref_nxt = ref_target;
    acc_nxt = acc_r;
    if (!conv_en) begin
      // turn-on and turn-off ramps belong to the soft-start logic
      ref_nxt = ref_goal;
      acc_nxt = 16'h0000;
    end else if (tick) begin
      if (reach) begin
        ref_nxt = ref_goal;
        acc_nxt = 16'h0000;
      end else begin
        ref_nxt = ref_goal > ref_target ? ref_target + step
                                        : ref_target - step;
        acc_nxt = acc_sum & ((16'h0001 << LSB_SHIFT) - 16'h0001);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_r <= 8'h00;
      acc_r      <= 16'h0000;
      ref_target <= 16'h0000;
      ref_goal   <= LOWER_RST;
      chk_r      <= 1'b0;
    end else begin
      tick_cnt_r <= tick ? 8'h00 : tick_cnt_r + 8'h01;
      acc_r      <= acc_nxt;
      ref_target <= ref_nxt;
      ref_goal   <= goal_nxt;
      chk_r      <= target_upd || lower_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky status; a new event wins over a clear in the same cycle
  logic warn;
  assign warn = chk_r && conv_en && (below || above);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status <= '0;
    end else begin
      status.none_above  <= warn || (status.none_above && !clear_faults);
      status.vout_word   <= warn || (status.vout_word && !clear_faults);
      status.vout_minmax <= warn || (status.vout_minmax && !clear_faults);
      status.cml_data    <= wr_bad || (status.cml_data && !clear_faults);
    end
  end
  assign alert_n = !(status.none_above || status.vout_word ||
                     status.vout_minmax || status.cml_data);

  ////////////////////////////////////////////////////////////////////////
  // checks
  AST_SLEW_BAD_FLAGS: assert property (@(posedge clk) disable iff (sys_rst)
    hit_slew && !wr_ok && !init_load |=>
      status.cml_data && !alert_n && $stable(slew_word_r))
    else $error("bad slew write not refused");
  AST_SLEW_RANGE: assert property (@(posedge clk) disable iff (sys_rst)
    hit_slew && wr_data == {5'h1C, 11'h001} && !init_load |=>
      $stable(slew_word_r))
    else $error("slew below range was stored");
  AST_SLEW_KEPT: assert property (@(posedge clk) disable iff (sys_rst)
    hit_slew && wr_ok && !init_load |=> slew_word_r == $past(wr_data))
    else $error("valid slew word not stored as written");
  AST_SCALE_FROZEN: assert property (@(posedge clk) disable iff (sys_rst)
    conv_en && !scale_apply && !init_load |=> $stable(scale_hw_r))
    else $error("scale changed while converting");
  AST_SCALE_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
    hit_scale && wr_ok && !conv_en && !init_load |=> ##1
      scale_exact == lin_to_q($past(wr_data, 2), SCALE_FRAC))
    else $error("idle scale write not applied");
  AST_DIVIDER: assert property (@(posedge clk) disable iff (sys_rst)
    scale_q16 > SCALE_Q_250 && scale_q16 <= SCALE_Q_500 |=>
      divider_sel == DIV_500)
    else $error("wrong divider for scale");
  AST_FLOOR: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 ref_goal >= $past(lower_r))
    else $error("goal below lower limit");
  AST_WARN: assert property (@(posedge clk) disable iff (sys_rst)
    warn |=> status.none_above && status.vout_word && status.vout_minmax
      && !alert_n)
    else $error("min/max warning not reported");
  AST_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    conv_en && !tick |=> $stable(ref_target))
    else $error("reference moved between ticks");
  AST_NO_SLEW_OFF: assert property (@(posedge clk) disable iff (sys_rst)
    !conv_en |=> ref_target == $past(ref_goal))
    else $error("reference slewed outside conversion");
  AST_ANSWER: assert property (@(posedge clk) disable iff (sys_rst)
    rd_word && cmd_code == CMD_LOWER |=> rd_valid && rd_data == $past(lower_r))
    else $error("word read not answered");

endmodule

/* File: logic/vss_pkg.sv */
// constants and carriers for the slew, scale and lower-limit commands
package vss_pkg;

  // command codes
  localparam logic [7:0]  CMD_SLEW      = 8'h27;
  localparam logic [7:0]  CMD_SCALE     = 8'h29;
  localparam logic [7:0]  CMD_LOWER     = 8'h2B;

  // linear-format field positions
  localparam int          EXP_MSB       = 15;
  localparam int          EXP_LSB       = 11;
  localparam int          MAN_MSB       = 10;

  // values after reset (mantissas come from the init load)
  localparam logic [4:0]  SLEW_EXP_RST  = 5'h1C;
  localparam logic [4:0]  SCALE_EXP_RST = 5'h19;
  localparam logic [10:0] MAN_RST       = 11'h000;
  localparam logic [15:0] LOWER_RST     = 16'h0000;

  // fraction bits used when decoding
  localparam int          SLEW_FRAC     = 8;
  localparam int          SCALE_FRAC    = 16;

  // valid slew range 0.067 .. 15.933 mV/us in 1/256 units
  localparam logic [31:0] SLEW_MIN_Q8   = 32'h0000_0012;
  localparam logic [31:0] SLEW_MAX_Q8   = 32'h0000_0FEE;
  localparam logic [7:0]  SLEW_CODE_MIN = 8'h01;
  localparam logic [7:0]  SLEW_CODE_MAX = 8'hFF;

  // divider thresholds 0.125, 0.25, 0.5 and top of range 1.0 in q16
  localparam logic [31:0] SCALE_Q_125   = 32'h0000_2000;
  localparam logic [31:0] SCALE_Q_250   = 32'h0000_4000;
  localparam logic [31:0] SCALE_Q_500   = 32'h0000_8000;
  localparam logic [31:0] SCALE_Q_MAX   = 32'h0001_0000;

  // divider selections
  localparam logic [1:0]  DIV_125       = 2'h0;
  localparam logic [1:0]  DIV_250       = 2'h1;
  localparam logic [1:0]  DIV_500       = 2'h2;
  localparam logic [1:0]  DIV_1000      = 2'h3;

  // slew tick: one step opportunity per microsecond
  localparam int          CLK_PERIOD_NS = 5;
  localparam int          TICK_NS       = 1000;
  localparam int          TICK_CYC      = TICK_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic none_above;
    logic vout_word;
    logic vout_minmax;
    logic cml_data;
  } vss_status_t;

  typedef struct packed {
    logic [10:0] slew_mantissa;
    logic [10:0] scale_mantissa;
    logic [15:0] lower;
  } vss_init_t;

endpackage

/* File: sim/vss_host.sv */
// host-side model issuing word writes and word reads
`timescale 1ns/1ps
module vss_host (
  // clock
  input  wire logic        clk,
  // word bus toward the device
  output logic      [7:0]  cmd_code,
  output logic             wr_word,
  output logic             rd_word,
  output logic      [15:0] wr_data,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid
);
  initial begin
    cmd_code = 8'h00;
    wr_word = 1'b0;
    rd_word = 1'b0;
    wr_data = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr_w(input logic [7:0] c, input logic [15:0] d);
    @(negedge clk);
    cmd_code = c;
    wr_data = d;
    wr_word = 1'b1;
    @(negedge clk);
    wr_word = 1'b0;
    // released data must not look like the last word
    wr_data = ~d;
  endtask
  task automatic rd_w(input logic [7:0] c, output logic [15:0] d,
                      output logic ok);
    @(negedge clk);
    cmd_code = c;
    rd_word = 1'b1;
    @(negedge clk);
    rd_word = 1'b0;
    ok = rd_valid;
    d = rd_data;
  endtask
endmodule

/* File: sim/test_vout_slew_scale_min_control.sv */
// bench for the slew, scale and lower-limit command logic
`timescale 1ns/1ps
module test_vout_slew_scale_min_control
  import vss_pkg::*;
;
  logic        clk, sys_rst, wr_word, rd_word, rd_valid, init_load;
  logic        conv_en, nvm_restore, uvlo, target_upd, clear_faults;
  logic        alert_n;
  logic [7:0]  cmd_code, slew_code;
  logic [15:0] wr_data, rd_data, nominal, trim, upper_limit;
  logic [15:0] ref_target, ref_goal;
  logic [1:0]  divider_sel;
  logic [31:0] scale_exact;
  vss_init_t   init_val;
  vss_status_t status;
  int          n_errors, tests_run, cycles;
  always #2.5 clk = ~clk;
  vss_core vss_core_inst (.clk(clk), .sys_rst(sys_rst), .cmd_code(cmd_code),
    .wr_word(wr_word), .rd_word(rd_word), .wr_data(wr_data),
    .rd_data(rd_data), .rd_valid(rd_valid), .init_load(init_load),
    .init_val(init_val), .conv_en(conv_en), .nvm_restore(nvm_restore),
    .analog_supply_input_uvlo(uvlo), .nominal(nominal), .trim(trim),
    .upper_limit(upper_limit), .target_upd(target_upd),
    .ref_target(ref_target), .ref_goal(ref_goal), .slew_code(slew_code),
    .divider_sel(divider_sel), .scale_exact(scale_exact),
    .clear_faults(clear_faults), .status(status), .alert_n(alert_n));
  vss_host vss_host_inst (.clk(clk), .cmd_code(cmd_code), .wr_word(wr_word),
    .rd_word(rd_word), .wr_data(wr_data), .rd_data(rd_data),
    .rd_valid(rd_valid));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] d;
    logic        ok;
    vss_host_inst.rd_w(c, d, ok);
    chk("read strobe", 32'h1, {31'h0, ok});
    chk("read word", {16'h0, e}, {16'h0, d});
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // 0 load, 1 target update, 2 clear, 3 restore
  task automatic kick(input int k);
    @(negedge clk);
    case (k)
      0: init_load = 1'b1;
      1: target_upd = 1'b1;
      2: clear_faults = 1'b1;
      default: nvm_restore = 1'b1;
    endcase
    @(negedge clk);
    {init_load, target_upd, clear_faults, nvm_restore} = 4'h0;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    vss_host_inst.wr_w(c, d);
    wt(3);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard, the whole run needs about eleven thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {init_load, conv_en, nvm_restore, uvlo, target_upd, clear_faults} = 6'h0;
    {nominal, trim, upper_limit} = {16'h0000, 16'h0000, 16'hFFFF};
    init_val = {11'h010, 11'h040, 16'h0000};
    repeat (10) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    rdchk(CMD_SLEW, 16'hE000);
    rdchk(CMD_SCALE, 16'hC800);
    rdchk(CMD_LOWER, 16'h0000);
    rdchk(8'h28, 16'h0000);
    kick(0);
    wt(2);
    rdchk(CMD_SLEW, 16'hE010);
    chk("slew code", 32'h10, {24'h0, slew_code});
    chk("divider", 32'h2, {30'h0, divider_sel});
    // off-grid rate: stored as written, applied rounded
    wr(CMD_SLEW, 16'hD009);
    rdchk(CMD_SLEW, 16'hD009);
    chk("slew code", 32'h02, {24'h0, slew_code});
    wr(CMD_SLEW, 16'hC012);
    chk("slew code", 32'h01, {24'h0, slew_code});
    wr(CMD_SLEW, 16'hD3FB);
    chk("slew code", 32'hFF, {24'h0, slew_code});
    chk("status", 32'h0, {28'h0, status});
    wr(CMD_SLEW, 16'hD3FC);
    wr(CMD_SLEW, 16'hE001);
    rdchk(CMD_SLEW, 16'hD3FB);
    chk("status", 32'h1, {28'h0, status});
    chk("alert", 32'h0, {31'h0, alert_n});
    kick(2);
    wt(1);
    chk("status", 32'h0, {28'h0, status});
    // scale thresholds while idle, exact q16 value kept
    for (int i = 0; i < 4; i++) begin
      wr(CMD_SCALE, 16'hE800 | 16'(i == 3 ? 5 : 1 << i));
      chk("divider", 32'(i), {30'h0, divider_sel});
      chk("scale", 32'(i == 3 ? 5 : 1 << i) << 13, scale_exact);
    end
    wr(CMD_SCALE, 16'hE809);
    chk("status", 32'h1, {28'h0, status});
    kick(2);
    conv_en = 1'b1;
    wr(CMD_SCALE, 16'hE803);
    rdchk(CMD_SCALE, 16'hE803);
    chk("divider", 32'h3, {30'h0, divider_sel});
    kick(3);
    wt(3);
    chk("divider", 32'h2, {30'h0, divider_sel});
    chk("scale", 32'h6000, scale_exact);
    // supply cycle below lockout also releases the stored scale
    wr(CMD_SCALE, 16'hE801);
    chk("divider", 32'h2, {30'h0, divider_sel});
    uvlo = 1'b1;
    wt(4);
    uvlo = 1'b0;
    wt(6);
    chk("divider", 32'h0, {30'h0, divider_sel});
    chk("scale", 32'h2000, scale_exact);
    // target clamps and min/max warning
    conv_en = 1'b0;
    nominal = 16'h0100;
    kick(1);
    wt(3);
    chk("goal", 32'h0100, {16'h0, ref_goal});
    chk("target", 32'h0100, {16'h0, ref_target});
    chk("status", 32'h0, {28'h0, status});
    conv_en = 1'b1;
    wr(CMD_LOWER, 16'h0200);
    chk("goal", 32'h0200, {16'h0, ref_goal});
    chk("status", 32'hE, {28'h0, status});
    chk("alert", 32'h0, {31'h0, alert_n});
    kick(2);
    {nominal, trim} = {16'h0300, 16'hFE00};
    kick(1);
    wt(3);
    chk("goal", 32'h0200, {16'h0, ref_goal});
    chk("status", 32'hE, {28'h0, status});
    kick(2);
    {trim, upper_limit} = {16'h0000, 16'h0250};
    kick(1);
    wt(3);
    chk("goal", 32'h0250, {16'h0, ref_goal});
    chk("status", 32'hE, {28'h0, status});
    // top rate is about 8 LSB per microsecond, 0x150 LSB to go
    wt(2000);
    chk("moving", 32'h1,
        {31'h0, ref_target > 16'h0108 && ref_target < 16'h0250});
    wt(9000);
    chk("target", 32'h0250, {16'h0, ref_target});
    give_verdict;
  end
endmodule
